// *** hw/pms_pkg.sv ***
// Shared constants for the module power-mode sequencer.
// Assumes a 100 MHz core clock; long counts are overridable at the top.
package pms_pkg;

	localparam int CLK_MHZ = 100;
	localparam int CLK_PERIOD_NS = 10;

	// Deadlines in their own units, as printed.
	localparam int MGMT_INIT_TIME_MS = 300;
	localparam int START_UP_TIME_MS = 300;
	localparam int COOLED_START_TIME_S = 90;
	localparam int POWER_UP_TIME_MS = 300;
	localparam int POWER_DOWN_TIME_MS = 300;
	localparam int HP_TO_LP_TIME_US = 200;

	// All times convert exactly to whole cycles.
	localparam longint MGMT_INIT_CYC = longint'(MGMT_INIT_TIME_MS) * 1000 * CLK_MHZ;
	localparam longint START_UP_CYC = longint'(START_UP_TIME_MS) * 1000 * CLK_MHZ;
	localparam longint COOLED_START_CYC = longint'(COOLED_START_TIME_S) * 1000000 * CLK_MHZ;
	localparam longint POWER_UP_CYC = longint'(POWER_UP_TIME_MS) * 1000 * CLK_MHZ;
	localparam longint POWER_DOWN_CYC = longint'(POWER_DOWN_TIME_MS) * 1000 * CLK_MHZ;
	localparam longint HP_TO_LP_CYC = longint'(HP_TO_LP_TIME_US) * CLK_MHZ;

	// Settle counts loaded on entry to waking or sleeping; each transition takes two cycles more.
	localparam int WAKE_SETTLE_CYC = 4;
	localparam int SLEEP_SETTLE_CYC = 2;

	localparam int CNT_W = 34;

	// Force bit power-up default by module class.
	localparam logic FORCE_DEFAULT_LOW_CLASS = 1'b0;
	localparam logic FORCE_DEFAULT_HIGH_CLASS = 1'b1;

	typedef enum logic [1:0] {
		PMS_LOW_POWER = 2'b00,
		PMS_WAKING = 2'b01,
		PMS_OPERATING = 2'b10,
		PMS_SLEEPING = 2'b11
	} pms_state_t;

endpackage : pms_pkg

// *** hw/pms_deadline.sv ***
// One deadline counter: starts on a trigger, stops when the target is reached.
// Assumes trigger and done are synchronous to clk_in.
`timescale 1ns/1ps
module pms_deadline #(
	parameter logic [pms_pkg::CNT_W-1:0] LIMIT = 34'h1
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic start_in,
	input wire logic done_in,
	output logic running_out,
	output logic expired_out
);

	logic [pms_pkg::CNT_W-1:0] count_reg;
	logic running_reg;
	logic expired_reg;
	wire at_limit = running_reg && (count_reg >= LIMIT - 34'h1);

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			count_reg <= '0;
			running_reg <= 1'b0;
			expired_reg <= 1'b0;
		end else if (start_in) begin
			count_reg <= '0;
			running_reg <= 1'b1;
			expired_reg <= 1'b0;
		end else if (done_in) begin
			running_reg <= 1'b0;
		end else if (running_reg) begin
			count_reg <= count_reg + 34'h1;
			if (at_limit) begin
				expired_reg <= 1'b1;
				running_reg <= 1'b0;
			end
		end
	end

	assign running_out = running_reg;
	assign expired_out = expired_reg;

endmodule : pms_deadline

// *** hw/pms_sequencer.sv ***
// Power-mode and start-up sequencer of a pluggable optical module.
// Assumes pins arrive asynchronously; management-side strobes are on clk_in.
//
// What this block does
// - Management interface ready within 300 ms after valid supplies or hot plug.
// - Uncooled low-class module fully operational within 300 ms of valid supplies.
// - Cooled low-class module fully operational within 90 s of valid supplies.
// - Uncooled module operational within 300 ms after a write enabling higher class.
// - Cooled module operational within 90 s after a write enabling higher class.
// - Back within lowest-class power inside 300 ms after a disabling write.
// - At start or reset release, low-power pin low means low-power mode.
// - At start or reset release, pin high means operate unless force bit blocks or a high-class build has class bit clear.
// - Force bit powers up to 0 for low-power class, 1 otherwise.
// - Transmitters on only when pin is 1 and force bit is 0.
// - Pin or reset assertion brings low power, transmitters off, within 200 us.
// - While module reset is low, stay in reset with interrupt deasserted.
`timescale 1ns/1ps
module pms_sequencer #(
	parameter logic HIGH_POWER_CLASS = 1'b0,
	parameter logic COOLED = 1'b0,
	parameter logic [pms_pkg::CNT_W-1:0] MGMT_INIT_CYC = 34'(pms_pkg::MGMT_INIT_CYC),
	parameter logic [pms_pkg::CNT_W-1:0] START_CYC = 34'(pms_pkg::START_UP_CYC),
	parameter logic [pms_pkg::CNT_W-1:0] COOLED_CYC = 34'(pms_pkg::COOLED_START_CYC),
	parameter logic [pms_pkg::CNT_W-1:0] POWER_DOWN_CYC = 34'(pms_pkg::POWER_DOWN_CYC)
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic low_power_request_n_in,
	input wire logic module_reset_n_in,
	input wire logic force_wr_in,
	input wire logic force_wr_data_in,
	input wire logic class_wr_in,
	input wire logic class_wr_data_in,
	input wire logic module_int_in,
	output logic mgmt_ready_out,
	output logic tx_enable_out,
	output logic high_power_out,
	output logic operational_out,
	output logic module_side_reset_n_out,
	output logic int_out,
	output logic force_low_power_bit_out,
	output logic class_enabled_out,
	output logic deadline_miss_out
);

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers.

	logic lpw_meta_reg;
	logic lpw_sync_reg;
	logic rst_meta_reg;
	logic rst_sync_reg;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			lpw_meta_reg <= 1'b0;
			lpw_sync_reg <= 1'b0;
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end else begin
			lpw_meta_reg <= low_power_request_n_in;
			lpw_sync_reg <= lpw_meta_reg;
			rst_meta_reg <= module_reset_n_in;
			rst_sync_reg <= rst_meta_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Control bits and mode decision.

	logic force_reg;
	logic class_reg;
	logic rst_sync_d_reg;
	logic boot_done_reg;
	pms_pkg::pms_state_t state_reg;
	pms_pkg::pms_state_t state_next;
	logic [2:0] settle_reg;
	logic [2:0] settle_next;

	wire in_reset = !rst_sync_reg;
	wire reset_release = rst_sync_reg && !rst_sync_d_reg;
	wire class_up = class_wr_in && class_wr_data_in;
	wire class_down = class_wr_in && !class_wr_data_in;
	wire class_ok = HIGH_POWER_CLASS ? class_reg : 1'b1;
	wire want_operate = lpw_sync_reg && !force_reg && class_ok && !in_reset;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			force_reg <= HIGH_POWER_CLASS ? pms_pkg::FORCE_DEFAULT_HIGH_CLASS
				: pms_pkg::FORCE_DEFAULT_LOW_CLASS;
			class_reg <= 1'b0;
			rst_sync_d_reg <= 1'b0;
			boot_done_reg <= 1'b0;
		end else begin
			rst_sync_d_reg <= rst_sync_reg;
			boot_done_reg <= 1'b1;
			if (force_wr_in) begin
				force_reg <= force_wr_data_in;
			end
			if (class_wr_in) begin
				class_reg <= class_wr_data_in;
			end
		end
	end

	// entry mode follows the pin after reset
	always_comb begin
		state_next = state_reg;
		settle_next = settle_reg;
		case (state_reg)
			pms_pkg::PMS_LOW_POWER: begin
				if (want_operate) begin
					state_next = pms_pkg::PMS_WAKING;
					settle_next = 3'(pms_pkg::WAKE_SETTLE_CYC);
				end
			end
			pms_pkg::PMS_WAKING: begin
				if (!want_operate) begin
					state_next = pms_pkg::PMS_LOW_POWER;
				end else if (settle_reg == 3'h0) begin
					state_next = pms_pkg::PMS_OPERATING;
				end else begin
					settle_next = settle_reg - 3'h1;
				end
			end
			pms_pkg::PMS_OPERATING: begin
				if (!want_operate) begin
					state_next = pms_pkg::PMS_SLEEPING;
					settle_next = 3'(pms_pkg::SLEEP_SETTLE_CYC);
				end
			end
			pms_pkg::PMS_SLEEPING: begin
				if (settle_reg == 3'h0) begin
					state_next = pms_pkg::PMS_LOW_POWER;
				end else begin
					settle_next = settle_reg - 3'h1;
				end
			end
			default: begin
				state_next = pms_pkg::PMS_LOW_POWER;
			end
		endcase
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_reg <= pms_pkg::PMS_LOW_POWER;
			settle_reg <= 3'h0;
		end else begin
			state_reg <= state_next;
			settle_reg <= settle_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Deadline counters.

	logic mgmt_ready_reg;
	logic tx_reg;
	logic hp_reg;
	logic oper_reg;
	logic int_reg;
	logic miss_reg;
	wire is_oper = state_reg == pms_pkg::PMS_OPERATING;
	wire is_low = state_reg == pms_pkg::PMS_LOW_POWER;
	wire boot_start = !boot_done_reg;
	wire up_start = boot_start || reset_release || class_up;
	wire [3:0] expired;

	pms_deadline #(.LIMIT(COOLED ? COOLED_CYC : START_CYC)) u_up (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.start_in(up_start),
		.done_in(is_oper || !want_operate),
		.running_out(),
		.expired_out(expired[0])
	);

	// power-down deadline
	// A low-class build never leaves its power limit, so only a high-class build times it.
	pms_deadline #(.LIMIT(POWER_DOWN_CYC)) u_down (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.start_in(class_down && HIGH_POWER_CLASS),
		.done_in(is_low),
		.running_out(),
		.expired_out(expired[1])
	);

	pms_deadline #(.LIMIT(34'(pms_pkg::HP_TO_LP_CYC))) u_hplp (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.start_in(is_oper && !want_operate),
		.done_in(is_low),
		.running_out(),
		.expired_out(expired[2])
	);

	pms_deadline #(.LIMIT(MGMT_INIT_CYC)) u_mgmt (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.start_in(boot_start),
		.done_in(mgmt_ready_reg),
		.running_out(),
		.expired_out(expired[3])
	);

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			mgmt_ready_reg <= 1'b0;
			tx_reg <= 1'b0;
			hp_reg <= 1'b0;
			oper_reg <= 1'b0;
			int_reg <= 1'b0;
			miss_reg <= 1'b0;
		end else begin
			mgmt_ready_reg <= boot_done_reg;
			tx_reg <= is_oper && want_operate;
			hp_reg <= !is_low;
			oper_reg <= is_oper;
			int_reg <= module_int_in && !in_reset;
			miss_reg <= miss_reg || (|expired);
		end
	end

	assign mgmt_ready_out = mgmt_ready_reg;
	assign tx_enable_out = tx_reg;
	assign high_power_out = hp_reg;
	assign operational_out = oper_reg;
	assign module_side_reset_n_out = rst_sync_reg;
	assign int_out = int_reg;
	assign force_low_power_bit_out = force_reg;
	assign class_enabled_out = class_reg;
	assign deadline_miss_out = miss_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Checks.

	a_tx_needs_pin: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		tx_reg |-> $past(lpw_sync_reg) && !$past(force_reg))
		else $error("Transmitter on without pin high and force clear.");

	a_int_in_reset: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		$past(in_reset) |-> !int_reg)
		else $error("Interrupt raised while module in reset.");

	a_fast_sleep: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(is_oper && !want_operate) |-> ##[1:6] is_low)
		else $error("Low power not reached after pin or reset assertion.");

	a_force_blocks: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		force_reg |-> ##2 !tx_reg)
		else $error("Force bit failed to block operation.");

	a_wake_op: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(is_low && want_operate) ##1 want_operate [*6] |=> is_oper)
		else $error("Operation not reached after wake request.");

	a_low_on_pin: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(!lpw_sync_reg && is_low) |=> !is_oper)
		else $error("Left low power while pin held low.");

	a_mgmt_ready: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		boot_done_reg |=> mgmt_ready_reg)
		else $error("Management interface not ready.");

	a_down_done: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(class_down && HIGH_POWER_CLASS && is_oper) |-> ##[1:8] is_low)
		else $error("Power-down did not complete.");

endmodule : pms_sequencer

// *** verification/pms_host_model.sv ***
// Host controller model: drives the low-power and reset pins and the write strobes.
// Assumes the bench clock; every change lands on a falling edge of clk_in.
`timescale 1ns/1ps
module pms_host_model (
	input wire logic clk_in,
	output logic low_power_request_n_out,
	output logic module_reset_n_out,
	output logic force_wr_out,
	output logic force_wr_data_out,
	output logic class_wr_out,
	output logic class_wr_data_out
);
	initial begin
		low_power_request_n_out = 1'b0;
		module_reset_n_out = 1'b0;
		force_wr_out = 1'b0;
		force_wr_data_out = 1'b0;
		class_wr_out = 1'b0;
		class_wr_data_out = 1'b0;
	end
	task automatic set_pins(input logic lp_n, input logic rst_n);
		@(negedge clk_in);
		low_power_request_n_out = lp_n;
		module_reset_n_out = rst_n;
	endtask : set_pins
	// force or class bit write
	// Data is inverted after the strobe so a stale value never looks valid.
	task automatic write_bit(input logic is_class, input logic value);
		@(negedge clk_in);
		force_wr_data_out = value;
		class_wr_data_out = value;
		force_wr_out = ~is_class;
		class_wr_out = is_class;
		@(negedge clk_in);
		force_wr_out = 1'b0;
		class_wr_out = 1'b0;
		force_wr_data_out = ~value;
		class_wr_data_out = ~value;
	endtask : write_bit
endmodule : pms_host_model

// *** verification/pms_sequencer_tb_top.sv ***
// Self-checking bench for the power-mode sequencer with a host model at its pins.
// Assumes shortened deadline counts; a second, cooled high-class build covers class writes.
`timescale 1ns/1ps
module pms_sequencer_tb_top;
	localparam logic [33:0] SIM_CYC = 34'h0c8;
	logic clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic module_int_in = 1'b0;
	logic lp_n, mrst_n, f_wr, f_d, c_wr, c_d;
	logic mgmt_ready, tx_en, high_pw, oper, side_rst_n, int_o, force_bit, class_en, miss;
	logic hp_lp_n, hp_mrst_n, hp_f_wr, hp_f_d, hp_c_wr, hp_c_d;
	logic hp_tx_en, hp_high_pw, hp_oper, hp_force_bit, hp_class_en, hp_miss;
	int fails = 0;
	int compares = 0;
	always #5 clk_in = ~clk_in;
	pms_host_model host (.clk_in(clk_in), .low_power_request_n_out(lp_n),
		.module_reset_n_out(mrst_n), .force_wr_out(f_wr), .force_wr_data_out(f_d),
		.class_wr_out(c_wr), .class_wr_data_out(c_d));
	pms_sequencer #(.HIGH_POWER_CLASS(1'b0), .COOLED(1'b0), .MGMT_INIT_CYC(SIM_CYC),
		.START_CYC(SIM_CYC), .COOLED_CYC(SIM_CYC), .POWER_DOWN_CYC(SIM_CYC)) i_dut (
		.clk_in(clk_in), .rst_n_in(rst_n_in), .low_power_request_n_in(lp_n),
		.module_reset_n_in(mrst_n), .force_wr_in(f_wr), .force_wr_data_in(f_d),
		.class_wr_in(c_wr), .class_wr_data_in(c_d), .module_int_in(module_int_in),
		.mgmt_ready_out(mgmt_ready), .tx_enable_out(tx_en), .high_power_out(high_pw),
		.operational_out(oper), .module_side_reset_n_out(side_rst_n), .int_out(int_o),
		.force_low_power_bit_out(force_bit), .class_enabled_out(class_en),
		.deadline_miss_out(miss));
	pms_host_model host_hp (.clk_in(clk_in), .low_power_request_n_out(hp_lp_n),
		.module_reset_n_out(hp_mrst_n), .force_wr_out(hp_f_wr), .force_wr_data_out(hp_f_d),
		.class_wr_out(hp_c_wr), .class_wr_data_out(hp_c_d));
	pms_sequencer #(.HIGH_POWER_CLASS(1'b1), .COOLED(1'b1), .MGMT_INIT_CYC(SIM_CYC),
		.START_CYC(SIM_CYC), .COOLED_CYC(SIM_CYC), .POWER_DOWN_CYC(SIM_CYC)) i_dut_hp (
		.clk_in(clk_in), .rst_n_in(rst_n_in), .low_power_request_n_in(hp_lp_n),
		.module_reset_n_in(hp_mrst_n), .force_wr_in(hp_f_wr), .force_wr_data_in(hp_f_d),
		.class_wr_in(hp_c_wr), .class_wr_data_in(hp_c_d), .module_int_in(module_int_in),
		.mgmt_ready_out(), .tx_enable_out(hp_tx_en), .high_power_out(hp_high_pw),
		.operational_out(hp_oper), .module_side_reset_n_out(), .int_out(),
		.force_low_power_bit_out(hp_force_bit), .class_enabled_out(hp_class_en),
		.deadline_miss_out(hp_miss));
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic got, input logic exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// Bounded wait; the bound sits far below the 200 us limit.
	task automatic settle(input logic want);
		for (int i = 0; i < 40 && tx_en !== want; i++) @(negedge clk_in);
	endtask : settle
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", compares, fails);
		if (fails == 0 && compares > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : wrap_up
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_start;
		chk(force_bit, 1'b0); // low-class default
		repeat (3) @(negedge clk_in);
		chk(mgmt_ready, 1'b1); // management ready
		settle(1'b1);
		chk(tx_en, 1'b1); // wakes unaided
		chk(oper, 1'b1); // operational after start
		chk(high_pw, 1'b1); // high power state
		$display("test start done");
	endtask : t_start
	task automatic t_force;
		host.write_bit(1'b0, 1'b1);
		settle(1'b0);
		chk(tx_en, 1'b0); // force blocks tx
		chk(force_bit, 1'b1); // force bit stored
		repeat (6) @(negedge clk_in);
		chk(high_pw, 1'b0); // low power reached
		host.write_bit(1'b0, 1'b0);
		settle(1'b1);
		chk(tx_en, 1'b1); // tx back on
		$display("test force done");
	endtask : t_force
	task automatic t_pin;
		host.set_pins(1'b0, 1'b1);
		settle(1'b0);
		chk(tx_en, 1'b0); // pin drops tx
		repeat (6) @(negedge clk_in);
		chk(high_pw, 1'b0); // low power reached
		host.set_pins(1'b1, 1'b1);
		settle(1'b1);
		chk(oper, 1'b1); // operating again
		$display("test pin done");
	endtask : t_pin
	task automatic t_reset;
		module_int_in = 1'b1;
		host.set_pins(1'b1, 1'b0);
		settle(1'b0);
		chk(tx_en, 1'b0); // reset drops tx
		chk(int_o, 1'b0); // interrupt held low
		chk(side_rst_n, 1'b0); // held in reset
		host.set_pins(1'b0, 1'b1);
		repeat (40) @(negedge clk_in);
		chk(high_pw, 1'b0); // release into low power
		chk(tx_en, 1'b0); // tx stays off
		chk(side_rst_n, 1'b1); // reset released
		chk(int_o, 1'b1); // interrupt passes out of reset
		host.set_pins(1'b1, 1'b1);
		settle(1'b1);
		chk(tx_en, 1'b1); // wakes after host action
		module_int_in = 1'b0;
		$display("test reset done");
	endtask : t_reset
	task automatic t_class;
		host.write_bit(1'b1, 1'b1);
		repeat (3) @(negedge clk_in);
		chk(class_en, 1'b1); // class enabled
		chk(oper, 1'b1); // operational
		host.write_bit(1'b1, 1'b1);
		host.write_bit(1'b1, 1'b0);
		repeat (3) @(negedge clk_in);
		chk(class_en, 1'b0); // last write wins
		repeat (250) @(negedge clk_in);
		chk(miss, 1'b0); // no deadline missed
		$display("test class done");
	endtask : t_class
	task automatic t_high;
		chk(hp_force_bit, 1'b1); // high-class default
		host_hp.set_pins(1'b1, 1'b1);
		repeat (40) @(negedge clk_in);
		chk(hp_high_pw, 1'b0); // force bit blocks start
		chk(hp_tx_en, 1'b0); // force bit keeps tx off
		host_hp.write_bit(1'b0, 1'b0);
		repeat (3) @(negedge clk_in);
		chk(hp_force_bit, 1'b0); // host clears force bit
		host_hp.write_bit(1'b1, 1'b1);
		repeat (12) @(negedge clk_in);
		chk(hp_class_en, 1'b1); // class enabled
		chk(hp_oper, 1'b1); // operational after class write
		chk(hp_tx_en, 1'b1); // pin high and force clear
		host_hp.write_bit(1'b1, 1'b0);
		repeat (8) @(negedge clk_in);
		chk(hp_class_en, 1'b0); // class disabled
		chk(hp_high_pw, 1'b0); // back to low power
		chk(hp_tx_en, 1'b0); // class removal stops tx
		repeat (250) @(negedge clk_in);
		chk(hp_miss, 1'b0); // no deadline missed
		$display("test high done");
	endtask : t_high
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		host.set_pins(1'b1, 1'b1);
		repeat (20) @(negedge clk_in);
		rst_n_in = 1'b1;
		t_start();
		t_force();
		t_pin();
		t_reset();
		t_class();
		t_high();
		wrap_up();
	end
	// The tests need well under 20 us; the limit leaves ample slack.
	initial begin
		#200000;
		fails++;
		wrap_up();
	end
endmodule : pms_sequencer_tb_top
